/* File: design/comd_decoder.sv */
/*
 * Opcode map decoder: primary, function and register-immediate maps,
 * exclusive-OR execution, exception flags and the result register pair.
 * Assumes a fetch stage on the same clock and register operands read
 * in the same cycle as the instruction word.
 */
`timescale 1ns/1ps

// Summary of operation
// - Register XOR of full 64 bits, no exception
// - Immediate XOR zero-extends, writes second field
// - Primary opcode rows bits 31..29, columns 28..26
// - Register-format class decodes function bits 5..0
// - Register-immediate class decodes bits 20..16
// - Reserved map entries raise reserved instruction
// - Unsupported multiply/divide, linked, coproc2 raise reserved
// - Register-format and register-immediate classes decode their designated extra field
// - Coprocessor opcodes check access, else unusable
// - System coprocessor class needs coprocessor 0 access
// - Float coprocessor class needs coprocessor 1 access
// - Shift-amount move and loads go to extension
// - 128-bit high/low result registers, half or full
// - Second-pipeline results map to bits 127..64
module comd_decoder
	import comd_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Fetch side
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [DATA_W-1:0] src_reg_a_i,
	input wire logic [DATA_W-1:0] src_reg_b_i,
	// Processor state
	input wire logic sys_cop_usable_i,
	input wire logic flt_cop_usable_i,
	// Result register writes
	input wire logic hi_lo_we_i,
	input wire logic hi_up_we_i,
	input wire logic lo_lo_we_i,
	input wire logic lo_up_we_i,
	input wire logic [HALF_W-1:0] hi_wdata_i,
	input wire logic [HALF_W-1:0] lo_wdata_i,
	// Pipeline side
	output comd_res_t res_o,
	output logic ext_route_o,
	output logic [ACC_W-1:0] high_result_o,
	output logic [ACC_W-1:0] low_result_o
);

	// Field extraction
	wire logic [5:0] opcode = instr_i[OP_HI:OP_LO];
	wire logic [2:0] op_row = instr_i[OP_HI:OP_HI-2];
	wire logic [2:0] op_col = instr_i[OP_HI-3:OP_LO];
	wire logic [5:0] fn_code = instr_i[FN_HI:FN_LO];
	wire logic [2:0] fn_row = fn_code[5:3];
	wire logic [2:0] fn_col = fn_code[2:0];
	wire logic [4:0] ri_code = instr_i[SRCB_HI:SRCB_LO];
	wire logic [4:0] fld_b = instr_i[SRCB_HI:SRCB_LO];
	wire logic [4:0] fld_d = instr_i[DST_HI:DST_LO];
	wire logic [IMM_W-1:0] imm = instr_i[IMM_W-1:0];

	// Class selection; register-format and register-immediate opcodes defer to their own field
	wire logic is_regfmt = (opcode == OP_REGFMT);
	wire logic is_reg_imm = (opcode == OP_REG_IMM);
	wire logic is_xor_imm = ({op_row, op_col} == OP_XOR_IMM);
	wire logic is_syscop = (opcode == OP_SYSCOP);
	wire logic is_fltcop = (opcode == OP_FLTCOP);
	wire logic is_xor = is_regfmt && ({fn_row, fn_col} == FN_XOR);

	// Reserved lookups; primary table also covers unsupported opcodes
	wire logic pri_rsvd = PRI_RSVD[opcode];
	wire logic fn_rsvd = is_regfmt && FN_RSVD[fn_code];
	wire logic ri_rsvd = is_reg_imm && RI_RSVD[ri_code];
	wire logic any_rsvd = pri_rsvd || fn_rsvd || ri_rsvd;

	// Coprocessor access checks
	wire logic cop_deny = (is_syscop && !sys_cop_usable_i)
		|| (is_fltcop && !flt_cop_usable_i);

	// Extension encodings routed out of the base datapath
	wire logic is_ext = (is_regfmt && fn_code == FN_SA_READ)
		|| (is_reg_imm && (ri_code == RI_SA_BYTE || ri_code == RI_SA_HALF));

	// Exclusive-OR datapaths
	wire logic [DATA_W-1:0] xor_reg = src_reg_a_i ^ src_reg_b_i;
	wire logic [DATA_W-1:0] xor_imm = src_reg_a_i ^ {{(DATA_W-IMM_W){1'b0}}, imm};

	comd_res_t res_d;
	comd_res_t res_q;
	logic ext_q;

	// Combine decode into the result record
	always_comb
	begin
		res_d = '0;
		res_d.valid = instr_valid_i;
		res_d.op = COMD_OP_OTHER;
		if (instr_valid_i)
		begin
			if (any_rsvd)
				res_d.exc_rsvd = 1'b1;
			else if (cop_deny)
			begin
				res_d.exc_cpu = 1'b1;
				res_d.op = COMD_OP_COP;
				res_d.cop_num = {1'b0, is_fltcop};
			end
			else if (is_xor)
			begin
				res_d.op = COMD_OP_XOR;
				res_d.dest = fld_d;
				res_d.result = xor_reg;
				res_d.we = 1'b1;
			end
			else if (is_xor_imm)
			begin
				res_d.op = COMD_OP_XOR_IMM;
				res_d.dest = fld_b;
				res_d.result = xor_imm;
				res_d.we = 1'b1;
			end
			else if (is_ext)
				res_d.op = COMD_OP_EXT;
			else if (is_syscop || is_fltcop)
			begin
				res_d.op = COMD_OP_COP;
				res_d.cop_num = {1'b0, is_fltcop};
			end
		end
		else
			res_d.op = COMD_OP_NONE;
	end

	// One register stage so every output comes from a flip-flop
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			res_q <= '0;
			ext_q <= 1'b0;
		end
		else
		begin
			res_q <= res_d;
			ext_q <= instr_valid_i && is_ext && !any_rsvd;
		end
	end

	assign res_o = res_q;
	assign ext_route_o = ext_q;

	// Result register pair
	comd_accum u_accum
	(
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.hi_lo_we_i(hi_lo_we_i),
		.hi_up_we_i(hi_up_we_i),
		.lo_lo_we_i(lo_lo_we_i),
		.lo_up_we_i(lo_up_we_i),
		.hi_wdata_i(hi_wdata_i),
		.lo_wdata_i(lo_wdata_i),
		.high_result_o(high_result_o),
		.low_result_o(low_result_o)
	);

	// Checks
	AST_XOR_RESULT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && is_xor) |=> (res_q.result == ($past(src_reg_a_i) ^ $past(src_reg_b_i))
			&& !res_q.exc_rsvd && !res_q.exc_cpu && res_q.we))
		else $error("register xor result wrong");
	AST_XOR_IMM_RESULT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && opcode == 6'h0e) |=> (res_q.op == COMD_OP_XOR_IMM
			&& res_q.result[63:16] == $past(src_reg_a_i[63:16])
			&& res_q.result[15:0] == ($past(src_reg_a_i[15:0]) ^ $past(instr_i[15:0]))
			&& res_q.dest == $past(instr_i[20:16])))
		else $error("immediate xor wrong");
	AST_XOR_FN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h26)
			|=> res_q.op == COMD_OP_XOR)
		else $error("xor function code not decoded");
	AST_RI_RSVD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && is_reg_imm && instr_i[20:19] == 2'b11 && instr_i[18:17] != 2'b00)
			|=> res_q.exc_rsvd)
		else $error("register-immediate reserved row missed");
	AST_UNSUP_OP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && (opcode == 6'h3c || opcode == 6'h3e || opcode == 6'h32))
			|=> res_q.exc_rsvd)
		else $error("unsupported opcode not refused");
	AST_SYS_COP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && opcode == 6'h10) |=> (res_q.exc_cpu == !$past(sys_cop_usable_i)))
		else $error("system coprocessor access check wrong");
	AST_FLT_COP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && opcode == 6'h11) |=> (res_q.exc_cpu == !$past(flt_cop_usable_i)
			&& res_q.cop_num == 2'h1))
		else $error("float coprocessor access check wrong");
	AST_EXT_ROUTE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && is_reg_imm && (ri_code == RI_SA_BYTE || ri_code == RI_SA_HALF))
			|=> ext_route_o)
		else $error("shift-amount load not routed");
	AST_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!instr_valid_i |=> !res_q.valid && !res_q.we && !res_q.exc_rsvd)
		else $error("idle cycle produced a result");
	// A reserved function code must never reach the register write port
	AST_FN_RSVD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && opcode == 6'h00 && instr_i[5:0] == 6'h3f) |=> res_q.exc_rsvd && !res_q.we)
		else $error("reserved function code not refused");
	AST_XOR_DEST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && is_xor) |=> res_q.dest == $past(instr_i[15:11]))
		else $error("register xor destination wrong");
	AST_COP_OK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(instr_valid_i && (opcode == 6'h10 || opcode == 6'h11) && sys_cop_usable_i
			&& flt_cop_usable_i) |=> !res_q.exc_cpu && res_q.op == COMD_OP_COP)
		else $error("granted coprocessor refused");

	COV_XOR: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) res_q.op == COMD_OP_XOR);
	COV_XOR_IMM: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		res_q.op == COMD_OP_XOR_IMM);
	COV_RSVD: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) res_q.exc_rsvd);
	COV_CPU: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) res_q.exc_cpu);
	COV_EXT: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) ext_route_o);

endmodule : comd_decoder

/* File: design/comd_pkg.sv */
/*
 * Constants and carrier types for the opcode map decoder.
 * Assumes a single core clock domain; no file here holds logic.
 */
package comd_pkg;

	// Instruction field positions
	localparam int OP_HI = 31;
	localparam int OP_LO = 26;
	localparam int SRCA_HI = 25;
	localparam int SRCA_LO = 21;
	localparam int SRCB_HI = 20;
	localparam int SRCB_LO = 16;
	localparam int DST_HI = 15;
	localparam int DST_LO = 11;
	localparam int FN_HI = 5;
	localparam int FN_LO = 0;
	localparam int IMM_W = 16;
	localparam int DATA_W = 64;

	// Primary map entries used by this block
	localparam logic [5:0] OP_REGFMT = 6'h00;
	localparam logic [5:0] OP_REG_IMM = 6'h01;
	localparam logic [5:0] OP_XOR_IMM = 6'h0e;
	localparam logic [5:0] OP_SYSCOP = 6'h10;
	localparam logic [5:0] OP_FLTCOP = 6'h11;

	// Function map entries
	localparam logic [5:0] FN_XOR = 6'h26;
	localparam logic [5:0] FN_SA_READ = 6'h28;

	// Register-immediate map entries (src_reg_b field)
	localparam logic [4:0] RI_SA_BYTE = 5'h18;
	localparam logic [4:0] RI_SA_HALF = 5'h19;

	// Reserved / unsupported bit maps, one bit per code (6-bit primary and function, 5-bit register-immediate)
	localparam logic [63:0] PRI_RSVD = 64'hd844_0000_0000_0000;
	localparam logic [63:0] FN_RSVD = 64'h8000_0000_0000_0000;
	localparam logic [31:0] RI_RSVD = 32'hfcf0_a0f0;
	localparam logic [63:0] FN_VALID = 64'hffff_ffff_ffff_ffff;

	// Accumulator halves
	localparam int ACC_W = 128;
	localparam int HALF_W = 64;

	// Operation classes handed to execution
	typedef enum logic [2:0]
	{
		COMD_OP_NONE = 3'h0,
		COMD_OP_XOR = 3'h1,
		COMD_OP_XOR_IMM = 3'h3,
		COMD_OP_EXT = 3'h2,
		COMD_OP_COP = 3'h6,
		COMD_OP_OTHER = 3'h7
	} comd_op_t;

	// Decoded result carried to the pipeline
	typedef struct packed
	{
		logic valid;
		comd_op_t op;
		logic [4:0] dest;
		logic [DATA_W-1:0] result;
		logic we;
		logic exc_rsvd;
		logic exc_cpu;
		logic [1:0] cop_num;
	} comd_res_t;

endpackage : comd_pkg

/* File: design/comd_accum.sv */
/*
 * 128-bit high/low result register pair.
 * Assumes the execution pipeline supplies write strobes per half.
 */
`timescale 1ns/1ps
module comd_accum
	import comd_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Write side
	input wire logic hi_lo_we_i,
	input wire logic hi_up_we_i,
	input wire logic lo_lo_we_i,
	input wire logic lo_up_we_i,
	input wire logic [HALF_W-1:0] hi_wdata_i,
	input wire logic [HALF_W-1:0] lo_wdata_i,
	// Read side
	output logic [ACC_W-1:0] high_result_o,
	output logic [ACC_W-1:0] low_result_o
);

	logic [ACC_W-1:0] hi_q;
	logic [ACC_W-1:0] lo_q;

	// Upper doubleword is the second-pipeline register, lower the default one
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hi_q <= '0;
			lo_q <= '0;
		end
		else
		begin
			if (hi_lo_we_i) hi_q[HALF_W-1:0] <= hi_wdata_i;
			if (hi_up_we_i) hi_q[ACC_W-1:HALF_W] <= hi_wdata_i;
			if (lo_lo_we_i) lo_q[HALF_W-1:0] <= lo_wdata_i;
			if (lo_up_we_i) lo_q[ACC_W-1:HALF_W] <= lo_wdata_i;
		end
	end

	assign high_result_o = hi_q;
	assign low_result_o = lo_q;

	AST_UPPER_HI: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		hi_up_we_i |=> hi_q[ACC_W-1:HALF_W] == $past(hi_wdata_i))
		else $error("upper high half not written");
	AST_LOWER_LO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(lo_lo_we_i && !lo_up_we_i) |=> lo_q[ACC_W-1:HALF_W] == $past(lo_q[ACC_W-1:HALF_W]))
		else $error("lower write disturbed upper low half");

endmodule : comd_accum

/* File: verif/comd_pipe_model.sv */
/*
 * Pipeline-side partner: a small register file feeding operands.
 * Assumes the decoder reads operands in the same cycle as the word.
 */
`timescale 1ns/1ps
module comd_pipe_model
	import comd_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Decoder side
	input wire logic [31:0] instr_i,
	input wire comd_res_t res_i,
	output logic [DATA_W-1:0] src_reg_a_o,
	output logic [DATA_W-1:0] src_reg_b_o
);
	logic [DATA_W-1:0] gpr [32];

	// Operand reads are combinational on the register fields
	assign src_reg_a_o = gpr[instr_i[SRCA_HI:SRCA_LO]];
	assign src_reg_b_o = gpr[instr_i[SRCB_HI:SRCB_LO]];

	// Reset preloads a distinct pattern so swapped operands show up
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			for (int i = 0; i < 32; i++)
				gpr[i] <= {8{8'(i)}} ^ 64'h0f3c_a500_5a00_c3f0;
		else if (res_i.valid && res_i.we && res_i.dest != 5'h00)
			gpr[res_i.dest] <= res_i.result;
	end
endmodule : comd_pipe_model

/* File: verif/tb_comd_decoder.sv */
/*
 * Self-checking bench for the opcode map decoder.
 * Assumes the pipeline model of comd_pipe_model.sv.
 */
`timescale 1ns/1ps
module tb_comd_decoder
	import comd_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic instr_valid_i = 1'b0;
	logic [31:0] instr_i = 32'h0;
	logic [DATA_W-1:0] src_a, src_b;
	logic sys_ok = 1'b0, flt_ok = 1'b0;
	logic hl_we = 1'b0, hu_we = 1'b0, ll_we = 1'b0, lu_we = 1'b0;
	logic [HALF_W-1:0] hi_wd = 64'h0, lo_wd = 64'h0;
	comd_res_t res_o;
	logic ext_route_o;
	logic [ACC_W-1:0] hi_res, lo_res;
	int n_fail = 0, compares = 0, cyc = 0;

	comd_decoder dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i), .src_reg_a_i(src_a),
		.src_reg_b_i(src_b), .sys_cop_usable_i(sys_ok), .flt_cop_usable_i(flt_ok),
		.hi_lo_we_i(hl_we), .hi_up_we_i(hu_we), .lo_lo_we_i(ll_we), .lo_up_we_i(lu_we),
		.hi_wdata_i(hi_wd), .lo_wdata_i(lo_wd), .res_o(res_o), .ext_route_o(ext_route_o),
		.high_result_o(hi_res), .low_result_o(lo_res));
	comd_pipe_model pipe (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
		.res_i(res_o), .src_reg_a_o(src_a), .src_reg_b_o(src_b));

	// 125 MHz core clock
	initial
	begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// Preloaded register value, known independently of the model
	function automatic logic [63:0] gv(input int i);
		return {8{8'(i)}} ^ 64'h0f3c_a500_5a00_c3f0;
	endfunction : gv

	task check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One word, answer is settled when this returns
	task send(input logic [31:0] w);
		@(posedge clk_sys_i) #1;
		instr_valid_i = 1'b1;
		instr_i = w;
		@(posedge clk_sys_i) #1;
		instr_valid_i = 1'b0;
	endtask : send

	// Back to back: immediate form, then register form
	task test_xor;
		@(posedge clk_sys_i) #1;
		instr_valid_i = 1'b1;
		instr_i = {OP_XOR_IMM, 5'd4, 5'd12, 16'h8001};
		@(posedge clk_sys_i) #1;
		instr_i = {OP_REGFMT, 5'd5, 5'd6, 5'd13, 5'd0, FN_XOR};
		check(res_o.result, gv(4) ^ 64'h8001);
		check({res_o.valid, res_o.op, res_o.dest}, {1'b1, COMD_OP_XOR_IMM, 5'd12});
		check({res_o.we, res_o.exc_rsvd, res_o.exc_cpu}, 3'h4);
		@(posedge clk_sys_i) #1;
		instr_valid_i = 1'b0;
		check(res_o.result, gv(5) ^ gv(6));
		check({res_o.valid, res_o.op, res_o.dest}, {1'b1, COMD_OP_XOR, 5'd13});
		check({res_o.we, res_o.exc_rsvd, res_o.exc_cpu}, 3'h4);
		$display("test xor done");
	endtask : test_xor

	// Every code of the register-immediate map
	task test_reg_imm;
		logic [31:0] rsvd;
		rsvd = 32'hfcf0_a0f0;
		for (int ri = 0; ri < 32; ri++)
		begin
			send({OP_REG_IMM, 5'd1, 5'(ri), 16'h0});
			check(res_o.exc_rsvd, rsvd[ri]);
			check(ext_route_o, ri == 24 || ri == 25);
		end
		$display("test reg-imm done");
	endtask : test_reg_imm

	// Unsupported primary codes and the shift-amount read
	task test_misc;
		send({6'h32, 26'h0});
		check({res_o.exc_rsvd, res_o.we}, 2'h2);
		send({6'h3c, 26'h0});
		check({res_o.exc_rsvd, res_o.we}, 2'h2);
		send({OP_REGFMT, 20'h0, 6'h3f});
		check({res_o.exc_rsvd, res_o.we}, 2'h2);
		send({OP_REGFMT, 20'h0, FN_SA_READ});
		check({ext_route_o, res_o.exc_rsvd}, 2'h2);
		$display("test misc done");
	endtask : test_misc

	// All four grant combinations for both coprocessor classes
	task test_cop;
		for (int k = 0; k < 4; k++)
		begin
			sys_ok = k[0];
			flt_ok = k[1];
			send({OP_SYSCOP, 26'h0});
			check({res_o.exc_cpu, res_o.cop_num}, {~k[0], 2'd0});
			send({OP_FLTCOP, 26'h0});
			check({res_o.exc_cpu, res_o.cop_num}, {~k[1], 2'd1});
		end
		$display("test cop done");
	endtask : test_cop

	// Half writes land in their own doubleword only
	task test_acc;
		@(posedge clk_sys_i) #1;
		{hl_we, hu_we, ll_we} = 3'h7;
		hi_wd = 64'h1111_2222_3333_4444;
		lo_wd = 64'h5555_6666_7777_8888;
		@(posedge clk_sys_i) #1;
		{hl_we, hu_we, ll_we, lu_we} = 4'h1;
		lo_wd = 64'h9999_aaaa_bbbb_cccc;
		check(hi_res[127:64], 64'h1111_2222_3333_4444);
		check(hi_res[63:0], 64'h1111_2222_3333_4444);
		check(lo_res[127:64], 64'h0);
		@(posedge clk_sys_i) #1;
		lu_we = 1'b0;
		check(lo_res[127:64], 64'h9999_aaaa_bbbb_cccc);
		check(lo_res[63:0], 64'h5555_6666_7777_8888);
		$display("test acc done");
	endtask : test_acc

	// Mid-run reset clears the result pair and the decoded record
	task test_reset;
		@(posedge clk_sys_i) #1;
		rst_n_i = 1'b0;
		#1;
		check(hi_res[127:64], 64'h0);
		check(lo_res[63:0], 64'h0);
		check({res_o.valid, res_o.we}, 2'h0);
		@(posedge clk_sys_i) #1;
		rst_n_i = 1'b1;
		$display("test reset done");
	endtask : test_reset

	task stop_test;
		$display("compares %0d failures %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// Hang guard well above the expected run length
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			stop_test();
		end
	end

	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		test_xor();
		test_reg_imm();
		test_misc();
		test_cop();
		test_acc();
		test_reset();
		stop_test();
	end
endmodule : tb_comd_decoder
